/* inc/urb_pkg.sv */
// Constants, register map and field layout of the UART receiver and break block
package urb_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_COUNT = 4'h3;
  localparam logic [3:0] OFS_BRD_HI = 4'h4;
  localparam logic [3:0] OFS_BRD_LO = 4'h5;
  localparam logic [3:0] OFS_TRIG = 4'h6;
  // Status bit positions
  localparam int ST_AVAIL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAMING = 3;
  localparam int ST_PARITY = 4;
  localparam int ST_RX_IDLE = 5;
  localparam int ST_TX_IDLE = 6;
  // Control bit positions
  localparam int CT_RX_EN = 0;
  localparam int CT_TX_EN = 1;
  localparam int CT_WORD9 = 2;
  localparam int CT_STOP2 = 3;
  localparam int CT_BREAK = 4;
  localparam int CT_RX_IE = 5;
  localparam int CT_NINTH = 6;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BRD_RST = 16'h0000;
  localparam logic [2:0] TRIG_RST = 3'h1;
  // Timing counts
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_SAMP_A = 4'h7;
  localparam logic [3:0] OS_SAMP_B = 4'h8;
  localparam logic [3:0] OS_VOTE = 4'h9;
  localparam logic [3:0] BRK_ZERO_BITS = 4'hD;
  localparam logic [3:0] TX_STOP_BITS = 4'h2;
  // Receive and transmit states
  typedef enum logic [2:0] {
    RX_HUNT = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_STOP1 = 3'b011, RX_STOP2 = 3'b100, RX_BRKWAIT = 3'b101
  } urb_rx_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_ZERO = 2'b10, TX_STOP = 2'b11
  } urb_tx_e;
endpackage

/* logic/urb_uart.sv */
// UART receive path with FIFO and error flags, plus break transmitter
`timescale 1ns/1ps
module urb_uart #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_serial_rx_pin,
  output logic o_tx_pin,
  // Receive interrupt request
  output logic o_rx_irq
);
  import urb_pkg::*;

  // Count fits depth plus one
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // Pointers wrap naturally only for power-of-two depths
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 7 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be 1, 2 or 4");
  end

  // Software registers
  logic [7:0] ctrl_r; // Control bits
  logic [15:0] baud_divisor_r; // Oversample period minus one
  logic [2:0] trig_r; // FIFO trigger level
  // Status flags
  logic rx_data_avail_flag_r;
  logic overrun_flag_r;
  logic noise_flag_r;
  logic framing_err_flag_r;
  logic rx_idle_flag_r;
  logic tx_idle_flag_r;
  logic status_armed_r; // Status read seen, data read will clear

  // Decoded strobes
  logic rd_status;
  logic rd_data;
  assign rd_status = i_rd && (i_addr == OFS_STATUS);
  assign rd_data = i_rd && (i_addr == OFS_DATA);

  // Pin synchroniser, three stages
  logic rx_s1_r, rx_s2_r, rx_s3_r;
  logic rx_line_r; // Filtered line level
  logic rx_line_prev_r; // For falling edge detect

  // Oversample prescaler
  logic [15:0] pre_cnt_r;
  logic os_tick;

  // Receiver state
  urb_rx_e rx_st_r;
  logic [3:0] rx_os_r; // Position within bit
  logic [3:0] rx_bits_r; // Data bits received
  logic [8:0] rx_shift_reg_r;
  logic rx_samp_a_r, rx_samp_b_r;
  logic rx_noise_r; // Noise seen this frame
  logic rx_stop_bad_r; // A stop bit sampled low

  // FIFO
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_r, rd_ptr_r;
  logic [CW-1:0] rx_fifo_count_r;
  logic push;
  logic pop;
  logic [8:0] push_word;

  // Transmitter
  urb_tx_e tx_st_r;
  logic [3:0] tx_os_r;
  logic [3:0] tx_bits_r;
  logic [16:0] brk_hold_r; // Cycles break control held while idle
  logic brk_armed;
  logic tx_bit_end;

  // Frame completion strobe from receiver
  logic frame_done;
  logic frame_break;
  logic vote;
  logic bit_end;
  logic last_bit;

  // Three-stage sampling; a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_line_r <= 1'b1;
      rx_line_prev_r <= 1'b1;
    end else begin
      rx_s1_r <= i_serial_rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_line_r <= rx_s3_r;
      end
      rx_line_prev_r <= rx_line_r;
    end
  end

  // Free-running oversample tick, one per divisor+1 clocks
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_cnt_r <= 16'h0000;
    end else if (pre_cnt_r >= baud_divisor_r) begin
      pre_cnt_r <= 16'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end
  assign os_tick = (pre_cnt_r >= baud_divisor_r);

  // Bit timing helpers
  assign vote = os_tick && (rx_os_r == OS_VOTE);
  assign bit_end = os_tick && (rx_os_r == OS_LAST);
  assign last_bit = ctrl_r[CT_WORD9] ? (rx_bits_r == 4'h8) : (rx_bits_r == 4'h7);
  // Majority of the three samples taken mid-bit
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Receiver sequencer: hunt, start, data, stops, break wait
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_st_r <= RX_HUNT;
      rx_os_r <= 4'h0;
      rx_bits_r <= 4'h0;
      rx_shift_reg_r <= 9'h000;
      rx_samp_a_r <= 1'b1;
      rx_samp_b_r <= 1'b1;
      rx_noise_r <= 1'b0;
      rx_stop_bad_r <= 1'b0;
    end else if (!ctrl_r[CT_RX_EN]) begin
      // Disabled receiver parks; re-enable restarts the hunt
      rx_st_r <= RX_HUNT;
      rx_os_r <= 4'h0;
    end else begin
      if (os_tick) begin
        rx_os_r <= rx_os_r + 4'h1;
        if (rx_os_r == OS_SAMP_A) begin
          rx_samp_a_r <= rx_line_r;
        end
        if (rx_os_r == OS_SAMP_B) begin
          rx_samp_b_r <= rx_line_r;
        end
      end
      // Three samples disagree: noise within the frame
      if (vote && rx_st_r != RX_HUNT && rx_st_r != RX_BRKWAIT &&
          !(rx_samp_a_r == rx_samp_b_r && rx_samp_b_r == rx_line_r)) begin
        rx_noise_r <= 1'b1;
      end
      unique case (rx_st_r)
        RX_HUNT: begin
          // Falling edge on an enabled receiver begins a frame
          if (rx_line_prev_r && !rx_line_r) begin
            rx_st_r <= RX_START;
            rx_os_r <= 4'h0;
            rx_noise_r <= 1'b0;
            rx_stop_bad_r <= 1'b0;
          end
        end
        RX_START: begin
          // A glitch that votes high is not a start bit
          if (vote && maj3(rx_samp_a_r, rx_samp_b_r, rx_line_r)) begin
            rx_st_r <= RX_HUNT;
          end else if (bit_end) begin
            rx_st_r <= RX_DATA;
            rx_bits_r <= 4'h0;
          end
        end
        RX_DATA: begin
          if (vote) begin
            rx_shift_reg_r <= {maj3(rx_samp_a_r, rx_samp_b_r, rx_line_r), rx_shift_reg_r[8:1]};
          end
          if (bit_end) begin
            rx_bits_r <= rx_bits_r + 4'h1;
            if (last_bit) begin
              rx_st_r <= RX_STOP1;
            end
          end
        end
        RX_STOP1: begin
          if (vote && !maj3(rx_samp_a_r, rx_samp_b_r, rx_line_r)) begin
            rx_stop_bad_r <= 1'b1;
          end
          if (bit_end) begin
            if (ctrl_r[CT_STOP2]) begin
              rx_st_r <= RX_STOP2;
            end else begin
              rx_st_r <= frame_break ? RX_BRKWAIT : RX_HUNT;
            end
          end
        end
        RX_STOP2: begin
          if (vote && !maj3(rx_samp_a_r, rx_samp_b_r, rx_line_r)) begin
            rx_stop_bad_r <= 1'b1;
          end
          if (bit_end) begin
            rx_st_r <= frame_break ? RX_BRKWAIT : RX_HUNT;
          end
        end
        RX_BRKWAIT: begin
          // Low line after a break is not a new start bit
          if (rx_line_r) begin
            rx_st_r <= RX_HUNT;
          end
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  // Frame ends at the last stop bit; break is all zeros with a bad stop
  assign frame_done = bit_end && ctrl_r[CT_RX_EN] &&
    ((rx_st_r == RX_STOP1 && !ctrl_r[CT_STOP2]) || rx_st_r == RX_STOP2);
  assign frame_break = (rx_stop_bad_r || (vote && !rx_line_r)) &&
    (ctrl_r[CT_WORD9] ? (rx_shift_reg_r == 9'h000) : (rx_shift_reg_r[8:1] == 8'h00));
  // Eight-bit words sit in the top of the shifter
  assign push_word = ctrl_r[CT_WORD9] ? rx_shift_reg_r : {1'b0, rx_shift_reg_r[8:1]};

  // FIFO push only when a slot is free; pop on data read
  assign push = frame_done && (rx_fifo_count_r < CW'(FIFO_DEPTH));
  assign pop = rd_data && (rx_fifo_count_r != '0);

  // Word storage; a full FIFO keeps its contents
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= push_word;
    end
  end

  // Pointers and word count
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      rx_fifo_count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      if (push && !pop) begin
        rx_fifo_count_r <= rx_fifo_count_r + CW'(1);
      end else if (pop && !push) begin
        rx_fifo_count_r <= rx_fifo_count_r - CW'(1);
      end
    end
  end

  // Status flags; hardware set wins over the software clear sequence
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_data_avail_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      noise_flag_r <= 1'b0;
      framing_err_flag_r <= 1'b0;
      rx_idle_flag_r <= 1'b1;
      status_armed_r <= 1'b0;
    end else begin
      if (rd_status) begin
        status_armed_r <= 1'b1;
      end else if (rd_data) begin
        status_armed_r <= 1'b0;
      end
      // Available clears only via status then data read, once empty
      if (push) begin
        rx_data_avail_flag_r <= 1'b1;
      end else if (rd_data && status_armed_r && rx_fifo_count_r <= CW'(1)) begin
        rx_data_avail_flag_r <= 1'b0;
      end
      if (frame_done && !push) begin
        overrun_flag_r <= 1'b1;
      end else if (rd_data && status_armed_r) begin
        overrun_flag_r <= 1'b0;
      end
      // Noise rises with the available flag on push
      if (push && (rx_noise_r || (vote && !(rx_samp_a_r == rx_samp_b_r && rx_samp_b_r == rx_line_r)))) begin
        noise_flag_r <= 1'b1;
      end else if (rd_data && status_armed_r) begin
        noise_flag_r <= 1'b0;
      end
      if (frame_done && (rx_stop_bad_r || (vote && !rx_line_r) || frame_break)) begin
        framing_err_flag_r <= 1'b1;
      end else if (rd_data && status_armed_r) begin
        framing_err_flag_r <= 1'b0;
      end
      // Busy from start detect, idle again once the stop is read
      if (rx_st_r == RX_HUNT && rx_line_prev_r && !rx_line_r && ctrl_r[CT_RX_EN]) begin
        rx_idle_flag_r <= 1'b0;
      end else if (frame_done || !ctrl_r[CT_RX_EN] ||
                   (rx_st_r == RX_START && vote && maj3(rx_samp_a_r, rx_samp_b_r, rx_line_r))) begin
        rx_idle_flag_r <= 1'b1;
      end
    end
  end

  // Interrupt pulse: push reaching trigger, or overrun
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_irq <= 1'b0;
    end else begin
      o_rx_irq <= ctrl_r[CT_RX_IE] &&
        ((push && (rx_fifo_count_r + CW'(1)) >= CW'(trig_r)) ||
         (frame_done && !push));
    end
  end

  // Break arming: control held while idle beyond divisor+1 clocks
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      brk_hold_r <= 17'h0_0000;
    end else if (ctrl_r[CT_BREAK] && tx_st_r == TX_IDLE && tx_idle_flag_r) begin
      if (!brk_armed) begin
        brk_hold_r <= brk_hold_r + 17'h0_0001;
      end
    end else begin
      brk_hold_r <= 17'h0_0000;
    end
  end
  assign brk_armed = brk_hold_r > ({1'b0, baud_divisor_r} + 17'h0_0001);
  assign tx_bit_end = os_tick && (tx_os_r == OS_LAST);

  // Break transmitter; it never touches any transmit-empty flag or irq
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_st_r <= TX_IDLE;
      tx_os_r <= 4'h0;
      tx_bits_r <= 4'h0;
      o_tx_pin <= 1'b1;
      tx_idle_flag_r <= 1'b1;
    end else if (!ctrl_r[CT_TX_EN]) begin
      // Clearing the enable stops at once
      tx_st_r <= TX_IDLE;
      o_tx_pin <= 1'b1;
      tx_idle_flag_r <= 1'b1;
    end else begin
      if (os_tick) begin
        tx_os_r <= tx_os_r + 4'h1;
      end
      unique case (tx_st_r)
        TX_IDLE: begin
          o_tx_pin <= 1'b1;
          if (brk_armed && os_tick && tx_os_r == OS_LAST) begin
            tx_st_r <= TX_START;
            tx_idle_flag_r <= 1'b0;
            o_tx_pin <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st_r <= TX_ZERO;
            tx_bits_r <= 4'h0;
          end
        end
        TX_ZERO: begin
          o_tx_pin <= 1'b0;
          if (tx_bit_end) begin
            if (tx_bits_r == BRK_ZERO_BITS - 4'h1) begin
              tx_bits_r <= 4'h0;
              // Held control runs another 13 zeros with no gap
              if (!ctrl_r[CT_BREAK]) begin
                tx_st_r <= TX_STOP;
                o_tx_pin <= 1'b1;
              end
            end else begin
              tx_bits_r <= tx_bits_r + 4'h1;
            end
          end
        end
        TX_STOP: begin
          o_tx_pin <= 1'b1;
          if (tx_bit_end) begin
            if (tx_bits_r == TX_STOP_BITS - 4'h1) begin
              tx_st_r <= TX_IDLE;
              tx_idle_flag_r <= 1'b1;
            end else begin
              tx_bits_r <= tx_bits_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Register writes
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= CTRL_RST;
      baud_divisor_r <= BRD_RST;
      trig_r <= TRIG_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        OFS_CTRL: ctrl_r <= i_wdata;
        OFS_BRD_HI: baud_divisor_r[15:8] <= i_wdata;
        OFS_BRD_LO: baud_divisor_r[7:0] <= i_wdata;
        OFS_TRIG: trig_r <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        OFS_STATUS: o_rdata <= {1'b0, tx_idle_flag_r, rx_idle_flag_r, 1'b0, framing_err_flag_r,
                                noise_flag_r, overrun_flag_r, rx_data_avail_flag_r};
        OFS_CTRL: o_rdata <= {ctrl_r[7], (rx_fifo_count_r != '0) && fifo_mem[rd_ptr_r][8], ctrl_r[5:0]};
        OFS_DATA: o_rdata <= (rx_fifo_count_r != '0) ? fifo_mem[rd_ptr_r][7:0] : 8'h00;
        OFS_COUNT: o_rdata <= 8'(rx_fifo_count_r);
        OFS_BRD_HI: o_rdata <= baud_divisor_r[15:8];
        OFS_BRD_LO: o_rdata <= baud_divisor_r[7:0];
        OFS_TRIG: o_rdata <= {5'h00, trig_r};
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule // urb_uart

/* tb/urb_uart_asserts.sv */
// Port-level assertions for the UART receiver and break block
`timescale 1ns/1ps
module urb_uart_asserts
  import urb_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Serial pins and interrupt
  input wire logic i_serial_rx_pin,
  input wire logic o_tx_pin,
  input wire logic o_rx_irq
);
  // Run lengths saturate so that long idles never wrap
  logic [11:0] tx_low_r; // Cycles the transmit pin has been low
  logic [7:0] tx_high_r; // Cycles the transmit pin has been high
  logic [7:0] rx_low_r; // Cycles the receive line has been low
  logic [7:0] rx_since_r; // Cycles since the receive line was last low

  // Transmit pin run lengths
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_low_r <= 12'h000;
      tx_high_r <= 8'h00;
    end else if (o_tx_pin) begin
      tx_low_r <= 12'h000;
      tx_high_r <= (tx_high_r == 8'hFF) ? tx_high_r : tx_high_r + 8'h01;
    end else begin
      tx_high_r <= 8'h00;
      tx_low_r <= (tx_low_r == 12'hFFF) ? tx_low_r : tx_low_r + 12'h001;
    end
  end

  // Receive line run lengths
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_low_r <= 8'h00;
      rx_since_r <= 8'hFF;
    end else if (!i_serial_rx_pin) begin
      rx_since_r <= 8'h00;
      rx_low_r <= (rx_low_r == 8'hFF) ? rx_low_r : rx_low_r + 8'h01;
    end else begin
      rx_low_r <= 8'h00;
      rx_since_r <= (rx_since_r == 8'hFF) ? rx_since_r : rx_since_r + 8'h01;
    end
  end

  // One clock and one reset for every property
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // Read data only stands in the cycle after a read
  property p_rdata_quiet;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read answer");
  // Interrupt is a single-cycle pulse
  property p_irq_pulse;
    o_rx_irq |=> !o_rx_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("receive interrupt longer than one cycle");
  // Interrupt only follows a frame seen on the line
  property p_irq_cause;
    o_rx_irq |-> rx_since_r < 8'd240;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("receive interrupt without a recent frame");
  // Word count never exceeds the FIFO depth
  property p_count_max;
    $past(i_rd) && $past(i_addr) == OFS_COUNT |-> o_rdata <= 8'(FIFO_DEPTH);
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("word count above FIFO depth");
  // Receiver not idle deep inside a low stretch of a frame
  property p_rx_busy;
    $past(i_rd) && $past(i_addr) == OFS_STATUS && $past(rx_low_r) inside {[24:120]} |-> !o_rdata[ST_RX_IDLE];
  endproperty
  a_rx_busy: assert property (p_rx_busy)
    else $error("receiver idle flag high inside a frame");
  // Transmitter not idle while it drives a break
  property p_tx_busy;
    $past(i_rd) && $past(i_addr) == OFS_STATUS && !$past(o_tx_pin) |-> !o_rdata[ST_TX_IDLE];
  endproperty
  a_tx_busy: assert property (p_tx_busy)
    else $error("transmit idle flag high during break");
  // Break low time is a start bit plus whole 13-bit characters
  property p_brk_len;
    $rose(o_tx_pin) |-> (tx_low_r % 12'd208) == 12'd16 && tx_low_r > 12'd16;
  endproperty
  a_brk_len: assert property (p_brk_len)
    else $error("break low time not start plus 13 bit multiples");
  // Two high stop bits precede any new low
  property p_brk_stops;
    $fell(o_tx_pin) |-> tx_high_r >= 8'd32;
  endproperty
  a_brk_stops: assert property (p_brk_stops)
    else $error("transmit pin fell before two stop bits");
endmodule // urb_uart_asserts

bind urb_uart urb_uart_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_serial_rx_pin(i_serial_rx_pin),
  .o_tx_pin(o_tx_pin),
  .o_rx_irq(o_rx_irq)
);

/* tb/urb_remote.sv */
// Remote serial transmitter feeding the block's receive line
`timescale 1ns/1ps
module urb_remote (
  // Clock
  input wire logic i_clk_sys,
  // Serial line toward the block
  output logic o_line
);
  localparam int BIT_CLKS = 16; // Divisor zero gives 16 clocks a bit
  // Line idles high, as with a pull-up
  initial o_line = 1'b1;

  // Hold the line at one level for whole bit times
  task automatic hold(input logic lvl, input int bits);
    repeat (bits * BIT_CLKS) begin
      @(posedge i_clk_sys);
      o_line <= lvl;
    end
  endtask

  // Start, data, stop, second stop level, then idle; gl picks a bit for a glitch
  // Glitch is two cycles, the shortest the input filter lets through; it hits only the third sample
  task automatic send(input logic [8:0] w, input int nb, input logic s2, input int gl);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge i_clk_sys);
        o_line <= (i == gl && (c == 10 || c == 11)) ? !w[i] : w[i];
      end
    end
    hold(1'b1, 1);
    hold(s2, 1);
    hold(1'b1, 1);
  endtask
endmodule // urb_remote

/* tb/urb_uart_bench.sv */
// Self-checking bench for the UART receiver and break block
`timescale 1ns/1ps
module urb_uart_bench;
  import urb_pkg::*;
  // Design port signals
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic rx_line;
  logic o_tx_pin;
  logic o_rx_irq;
  // Bookkeeping
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int irqs = 0;
  int tx_low = 0;
  logic [7:0] rv;
  localparam int CEIL = 20000; // Tests need about a sixth of this

  always #5 i_clk_sys = ~i_clk_sys;

  // Interrupt pulses, break low time and hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (o_rx_irq === 1'b1) irqs++;
    if (o_tx_pin === 1'b0) tx_low++;
    if (cycles == CEIL) begin
      mismatches++;
      tally_and_finish();
    end
  end

  urb_uart #(.FIFO_DEPTH(4)) i_dut (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_serial_rx_pin(rx_line),
    .o_tx_pin(o_tx_pin),
    .o_rx_irq(o_rx_irq)
  );
  urb_remote i_remote (
    .i_clk_sys(i_clk_sys),
    .o_line(rx_line)
  );

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    chk(what, {8'h00, rv}, {8'h00, exp});
  endtask
  // Bounded wait for a transmit pin level
  task automatic wait_tx(input logic lvl, input int lim);
    for (int t = 0; t < lim && o_tx_pin !== lvl; t++) begin
      @(posedge i_clk_sys);
      #1;
    end
    chk("tx pin", {15'h0000, o_tx_pin}, {15'h0000, lvl});
  endtask
  // One frame, then control, status, data and the clear sequence
  task automatic rx_one(input logic [8:0] w, input int nb, input logic s2, input int gl,
                        input logic [7:0] ctl, input logic [7:0] st, input logic [7:0] dat);
    i_remote.send(w, nb, s2, gl);
    repeat (8) @(posedge i_clk_sys);
    rc("ctrl", OFS_CTRL, ctl);
    rc("status", OFS_STATUS, st);
    rc("data", OFS_DATA, dat);
    rc("status clear", OFS_STATUS, 8'h60);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rc("status rst", OFS_STATUS, 8'h60);
    rc("ctrl rst", OFS_CTRL, CTRL_RST);
    rc("count rst", OFS_COUNT, 8'h00);
    rc("trig rst", OFS_TRIG, 8'h01);
    rc("unmapped", 4'h9, 8'h00);
    wr(OFS_BRD_HI, 8'h12);
    rc("brd hi", OFS_BRD_HI, 8'h12);
    wr(OFS_BRD_HI, 8'h00);
    wr(OFS_BRD_LO, 8'h00);
    rc("brd lo", OFS_BRD_LO, 8'h00);
    // Receiver off ignores the line
    i_remote.send(9'h0AA, 8, 1'b1, -1);
    rc("count off", OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h21);
    rx_one(9'h0A5, 8, 1'b1, -1, 8'h21, 8'h61, 8'hA5);
    chk("irq one", 16'(irqs), 16'd1);
    wr(OFS_CTRL, 8'h25);
    rx_one(9'h13C, 9, 1'b1, -1, 8'h65, 8'h61, 8'h3C);
    wr(OFS_CTRL, 8'h21);
    rx_one(9'h05A, 8, 1'b1, 3, 8'h21, 8'h65, 8'h5A);
    wr(OFS_CTRL, 8'h29);
    rx_one(9'h0C3, 8, 1'b0, -1, 8'h29, 8'h69, 8'hC3);
    chk("irq noise", 16'(irqs), 16'd4);
    // Five words into a four-deep FIFO
    wr(OFS_CTRL, 8'h21);
    wr(OFS_TRIG, 8'h04);
    for (int k = 1; k <= 5; k++) i_remote.send(9'(k * 17), 8, 1'b1, -1);
    repeat (8) @(posedge i_clk_sys);
    chk("irq ovr", 16'(irqs), 16'd6);
    rc("count full", OFS_COUNT, 8'h04);
    rc("status ovr", OFS_STATUS, 8'h63);
    rc("word1", OFS_DATA, 8'h11);
    rc("ovr cleared", OFS_STATUS, 8'h61);
    rc("word2", OFS_DATA, 8'h22);
    rc("word3", OFS_DATA, 8'h33);
    rc("count one", OFS_COUNT, 8'h01);
    rc("status arm", OFS_STATUS, 8'h61);
    rc("word4", OFS_DATA, 8'h44);
    rc("status empty", OFS_STATUS, 8'h60);
    rc("empty pop", OFS_DATA, 8'h00);
    rc("count empty", OFS_COUNT, 8'h00);
    // Software restarts reception after an overrun
    wr(OFS_CTRL, 8'h20);
    wr(OFS_CTRL, 8'h21);
    // Long break on the line, status looked at mid-break
    wr(OFS_TRIG, 8'h01);
    fork
      i_remote.hold(1'b0, 20);
      begin
        repeat (60) @(posedge i_clk_sys);
        rc("status mid", OFS_STATUS, 8'h40);
      end
    join
    i_remote.hold(1'b1, 2);
    rc("count brk", OFS_COUNT, 8'h01);
    chk("irq brk", 16'(irqs), 16'd7);
    rc("status brk", OFS_STATUS, 8'h69);
    rc("data brk", OFS_DATA, 8'h00);
    rc("brk clear", OFS_STATUS, 8'h60);
    rx_one(9'h03C, 8, 1'b1, -1, 8'h21, 8'h61, 8'h3C);
    // Break transmission held into a second character
    tx_low = 0;
    wr(OFS_CTRL, 8'h33);
    wait_tx(1'b0, 100);
    rc("tx busy", OFS_STATUS, 8'h20);
    repeat (250) @(posedge i_clk_sys);
    wr(OFS_CTRL, 8'h23);
    wait_tx(1'b1, 800);
    repeat (40) @(posedge i_clk_sys);
    chk("brk low", 16'(tx_low), 16'd432);
    rc("tx idle", OFS_STATUS, 8'h60);
    chk("irq tx", 16'(irqs), 16'd8);
    tally_and_finish();
  end
endmodule // urb_uart_bench
